// ==== core/emi_mac_regs.v ====
// Event flags, interrupt mask, PHY management shifter and hash filter.
// Assumes APB master, synchronous event pulses from the MAC datapaths.
`timescale 1ns/100ps
`include "emi_defines.vh"
module emi_mac_regs #(
    parameter MAN_BITS = `EMI_MAN_BITS
) (
    input wire MCLK,
    input wire RESET,
    input wire PSEL,
    input wire PENABLE,
    input wire PWRITE,
    input wire [11:0] PADDR,
    input wire [31:0] PWDATA,
    output wire [31:0] PRDATA,
    output wire PREADY,
    output wire PSLVERR,
    input wire RX_STORE_FAIL,
    input wire RX_COMPLETE,
    input wire RX_NO_BUFFER,
    input wire TX_UNDERRUN,
    input wire TX_RETRY_LIMIT,
    input wire TX_FRAME_DONE,
    input wire TX_ALL_DONE,
    input wire TX_BUFFER_NOT_QUEUED,
    input wire DMA_ABORT,
    input wire LINK_PIN,
    input wire [5:0] HASH_INDEX,
    output wire HASH_HIT,
    output wire IRQ,
    output wire MDC,
    output wire MDIO_O,
    output wire MDIO_OE,
    input wire MDIO_I
);
    reg [31:0] prdata_q;
    reg [`EMI_EVT_BITS-1:0] evt_q;
    reg [`EMI_EVT_BITS-1:0] evt_d;
    reg [`EMI_EVT_BITS-1:0] mask_q;
    reg [1:0] clkdiv_q;
    reg rx_ovr_q;
    reg [MAN_BITS-1:0] man_q;
    reg [5:0] bits_q;
    reg busy_q;
    reg busy_d1_q;
    reg [5:0] div_q;
    reg mdc_q;
    reg link_q;
    reg link_seen_q;
    reg [63:0] hash_q;
    wire acc;
    wire wr;
    wire rd;
    wire evt_rd;
    wire tx_wr;
    wire man_wr;
    wire [5:0] div_top;
    wire [`EMI_EVT_BITS-1:0] evt_set;

    function hit_addr;
        input [11:0] a;
        input [11:0] ofs;
        begin
            hit_addr = (a == ofs);
        end
    endfunction

    assign acc = PSEL & PENABLE;
    assign wr = acc & PWRITE;
    assign rd = acc & ~PWRITE;
    assign PREADY = 1'b1;
    assign PSLVERR = 1'b0;
    assign PRDATA = prdata_q;
    assign evt_rd = rd & hit_addr(PADDR, `EMI_OFS_EVT);
    // Transmit pointer and length share one decode slot
    assign tx_wr = wr & hit_addr(PADDR, `EMI_OFS_TXST);
    assign man_wr = wr & hit_addr(PADDR, `EMI_OFS_MAN);

    // Read data is combinational from state, registered for the bus
    always @(posedge MCLK) begin
        if (RESET) begin
            prdata_q <= 32'h0;
        end else if (PSEL & ~PENABLE & ~PWRITE) begin
            case (PADDR)
                `EMI_OFS_CTRL:
                    prdata_q <= {20'h0, clkdiv_q, 10'h0};
                `EMI_OFS_STAT:
                    prdata_q <= {29'h0, busy_q, MDIO_I, 1'b0};
                `EMI_OFS_TXST:
                    prdata_q <= {27'h0, TX_BUFFER_NOT_QUEUED, 4'h0};
                `EMI_OFS_RXST:
                    prdata_q <= {29'h0, rx_ovr_q, 2'h0};
                `EMI_OFS_EVT:
                    prdata_q <= {20'h0, evt_q};
                `EMI_OFS_IMASK:
                    prdata_q <= {20'h0, mask_q};
                `EMI_OFS_MAN:
                    prdata_q <= man_q;
                `EMI_OFS_HLO:
                    prdata_q <= hash_q[31:0];
                `EMI_OFS_HHI:
                    prdata_q <= hash_q[63:32];
                default:
                    prdata_q <= 32'h0;
            endcase
        end
    end

    // Event sources; sets beat the clear-on-read
    assign evt_set[`EMI_EVT_DONE] = busy_d1_q & ~busy_q;
    assign evt_set[`EMI_EVT_RX_COMPLETE_EVT] = RX_COMPLETE;
    assign evt_set[`EMI_EVT_RNBUF] = RX_NO_BUFFER;
    assign evt_set[`EMI_EVT_TX_QUEUE_OVERRUN_EVT] = tx_wr & ~TX_BUFFER_NOT_QUEUED;
    assign evt_set[`EMI_EVT_TX_FETCH_UNDERRUN_EVT] = TX_UNDERRUN;
    assign evt_set[`EMI_EVT_RETRY_LIMIT_EVT] = TX_RETRY_LIMIT;
    assign evt_set[`EMI_EVT_TFREE] = TX_BUFFER_NOT_QUEUED;
    assign evt_set[`EMI_EVT_TDONE] = TX_FRAME_DONE;
    assign evt_set[`EMI_EVT_TALL] = TX_ALL_DONE;
    assign evt_set[`EMI_EVT_LINK] = link_seen_q & (link_q != LINK_PIN);
    assign evt_set[`EMI_EVT_RX_OVERRUN_EVT] = RX_STORE_FAIL;
    assign evt_set[`EMI_EVT_ABT] = DMA_ABORT;

    always @* begin
        evt_d = evt_q;
        // Clear only what the read reported; a flag set after setup survives
        if (evt_rd) begin
            evt_d = evt_q & ~prdata_q[`EMI_EVT_BITS-1:0];
        end
        // Free slot flag drops once both slots are taken
        if (~TX_BUFFER_NOT_QUEUED) begin
            evt_d[`EMI_EVT_TFREE] = 1'b0;
        end
        evt_d = evt_d | evt_set;
    end

    always @(posedge MCLK) begin
        if (RESET) begin
            evt_q <= {`EMI_EVT_BITS{1'b0}};
            mask_q <= `EMI_MASK_RST;
            clkdiv_q <= `EMI_CLKDIV_RST;
            rx_ovr_q <= 1'b0;
            hash_q <= 64'h0;
            link_q <= 1'b0;
            link_seen_q <= 1'b0;
        end else begin
            evt_q <= evt_d;
            link_q <= LINK_PIN;
            link_seen_q <= 1'b1;
            if (wr & hit_addr(PADDR, `EMI_OFS_IEN)) begin
                mask_q <= mask_q & ~PWDATA[`EMI_EVT_BITS-1:0];
            end else if (wr & hit_addr(PADDR, `EMI_OFS_IDIS)) begin
                mask_q <= mask_q | PWDATA[`EMI_EVT_BITS-1:0];
            end
            if (wr & hit_addr(PADDR, `EMI_OFS_CTRL)) begin
                clkdiv_q <= PWDATA[`EMI_CLKDIV_LSB+1:`EMI_CLKDIV_LSB];
            end
            // Overrun status: set wins over the one-write clear
            if (RX_STORE_FAIL) begin
                rx_ovr_q <= 1'b1;
            end else if (wr & hit_addr(PADDR, `EMI_OFS_RXST)
                         & PWDATA[`EMI_RXST_OVR]) begin
                rx_ovr_q <= 1'b0;
            end
            if (wr & hit_addr(PADDR, `EMI_OFS_HLO)) begin
                hash_q[31:0] <= PWDATA;
            end
            if (wr & hit_addr(PADDR, `EMI_OFS_HHI)) begin
                hash_q[63:32] <= PWDATA;
            end
        end
    end

    assign IRQ = |(evt_q & ~mask_q);
    assign HASH_HIT = hash_q[HASH_INDEX];

    // Half-period count: 4, 8, 16 or 32 system clocks
    assign div_top = 6'h4 << clkdiv_q;

    // Management shifter; shifts on the falling MDC edge
    always @(posedge MCLK) begin
        if (RESET) begin
            man_q <= {MAN_BITS{1'b0}};
            bits_q <= 6'h0;
            busy_q <= 1'b0;
            busy_d1_q <= 1'b0;
            div_q <= 6'h0;
            mdc_q <= 1'b0;
        end else begin
            busy_d1_q <= busy_q;
            if (man_wr) begin
                // Field layout is software's duty; loaded as written
                man_q <= PWDATA;
                bits_q <= 6'h0;
                busy_q <= 1'b1;
                div_q <= 6'h0;
                mdc_q <= 1'b0;
            end else if (busy_q) begin
                if (div_q == div_top - 6'h1) begin
                    div_q <= 6'h0;
                    mdc_q <= ~mdc_q;
                    if (mdc_q) begin
                        // Sample pin into LSB as MSB leaves
                        man_q <= {man_q[MAN_BITS-2:0], MDIO_I};
                        if (bits_q == MAN_BITS - 1) begin
                            busy_q <= 1'b0;
                        end
                        bits_q <= bits_q + 6'h1;
                    end
                end else begin
                    div_q <= div_q + 6'h1;
                end
            end
        end
    end

    assign MDC = mdc_q;
    assign MDIO_O = man_q[MAN_BITS-1];
    // Released during read turnaround would need frame decode; kept simple
    assign MDIO_OE = busy_q;
endmodule

// ==== pkg/emi_defines.vh ====
// Constants for the MAC event flag and PHY management block.
// Assumes a 32-bit APB slave with word-aligned registers.
// Overview of operation
// - Receive DMA store failure sets overrun flags
// - Management done sets bit 0, clears on read
// - Frame written to memory sets bit 1
// - No receive buffer sets bit 2
// - Transmit write while queue full sets bit 3
// - Transmit fetch too late sets bit 4
// - Retry limit exceeded sets bit 5
// - Bit 6 set while transmit slot free
// - Frame done sets bit 7, all done bit 8
// - Link pin change sets bit 9
// - DMA abort sets bit 11
// - Enable write of one enables source
// - Disable write of one disables source
// - Mask view reads one for disabled sources
// - Maintenance write loads and starts shifting
// - Drive MSB out, sample into LSB
// - Shift end raises done and idles logic
// - Data field holds write or returned data
// - 64-bit hash filter over two registers
// - Hashed frame accepted when selected bit set
// - Management clock divides by 8 to 64
// - Status shows data pin and busy bit
`ifndef EMI_DEFINES_VH
`define EMI_DEFINES_VH
`define EMI_OFS_CTRL 12'h000
`define EMI_OFS_STAT 12'h004
`define EMI_OFS_TXST 12'h008
`define EMI_OFS_RXST 12'h00c
`define EMI_OFS_EVT 12'h010
`define EMI_OFS_IEN 12'h014
`define EMI_OFS_IDIS 12'h018
`define EMI_OFS_IMASK 12'h01c
`define EMI_OFS_MAN 12'h020
`define EMI_OFS_HLO 12'h024
`define EMI_OFS_HHI 12'h028
`define EMI_EVT_BITS 12
`define EMI_EVT_DONE 0
`define EMI_EVT_RX_COMPLETE_EVT 1
`define EMI_EVT_RNBUF 2
`define EMI_EVT_TX_QUEUE_OVERRUN_EVT 3
`define EMI_EVT_TX_FETCH_UNDERRUN_EVT 4
`define EMI_EVT_RETRY_LIMIT_EVT 5
`define EMI_EVT_TFREE 6
`define EMI_EVT_TDONE 7
`define EMI_EVT_TALL 8
`define EMI_EVT_LINK 9
`define EMI_EVT_RX_OVERRUN_EVT 10
`define EMI_EVT_ABT 11
`define EMI_MASK_RST 12'hfff
`define EMI_CLKDIV_LSB 10
`define EMI_CLKDIV_RST 2'h2
`define EMI_STAT_PIN 1
`define EMI_STAT_BUSY 2
`define EMI_TXST_OVR 0
`define EMI_TXST_FREE 4
`define EMI_RXST_OVR 2
`define EMI_MAN_BITS 32
`endif

// ==== testbench/emi_phy_model.sv ====
// Far-side PHY stand-in on the management link.
// Assumes MDC rises once per bit; the wire is resolved here.
`timescale 1ns/100ps
module emi_phy_model (
    input wire mdc,
    input wire mdo,
    input wire moe,
    output wire mdi,
    output reg [31:0] rx
);
    reg last = 1'b0;
    // Released line shows the inverse, never a stale copy
    assign mdi = moe ? mdo : ~last;
    always @(posedge mdc) begin
        rx <= {rx[30:0], mdo};
        last <= mdo;
    end
endmodule

// ==== testbench/emi_mac_regs_assertions.sv ====
// Port checker for the MAC register block.
// Assumes one clock domain and a zero-wait APB slave.
`timescale 1ns/100ps
module emi_mac_regs_assertions (
    input wire MCLK,
    input wire RESET,
    input wire PSEL,
    input wire PENABLE,
    input wire PWRITE,
    input wire [11:0] PADDR,
    input wire [31:0] PWDATA,
    input wire [31:0] PRDATA,
    input wire [5:0] HASH_INDEX,
    input wire HASH_HIT,
    input wire IRQ,
    input wire MDC,
    input wire MDIO_OE,
    input wire MDIO_I
);
    default clocking @(posedge MCLK); endclocking
    default disable iff (RESET);
    wire wr = PSEL && PENABLE && PWRITE;
    wire rs = PSEL && !PENABLE && !PWRITE;
    property p_rst; $fell(RESET) |-> !IRQ && !MDIO_OE && !MDC; endproperty
    a_rst: assert property (p_rst) else $error("dirty reset");
    property p_start; wr && PADDR == 12'h020 |=> MDIO_OE; endproperty
    a_start: assert property (p_start) else $error("no start");
    property p_hold; MDIO_OE && $changed(MDC) |=> $stable(MDC)[*3]; endproperty
    a_hold: assert property (p_hold) else $error("mdc fast");
    property p_idle; !MDIO_OE |-> !MDC; endproperty
    a_idle: assert property (p_idle) else $error("mdc idle");
    property p_busy; rs && PADDR == 12'h004 |=> PRDATA[2] == $past(MDIO_OE);
    endproperty
    a_busy: assert property (p_busy) else $error("busy bit");
    property p_pin; rs && PADDR == 12'h004 |=> PRDATA[1] == $past(MDIO_I);
    endproperty
    a_pin: assert property (p_pin) else $error("pin bit");
    property p_hash; wr && PADDR == 12'h024 && !HASH_INDEX[5] |=>
        HASH_INDEX != $past(HASH_INDEX) ||
        HASH_HIT == $past(PWDATA[HASH_INDEX[4:0]]); endproperty
    a_hash: assert property (p_hash) else $error("hash bit");
    property p_len; $rose(MDIO_OE) |-> ##240 MDIO_OE; endproperty
    a_len: assert property (p_len) else $error("frame short");
endmodule
bind emi_mac_regs emi_mac_regs_assertions i_chk (.MCLK(MCLK),
    .RESET(RESET), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .IRQ(IRQ),
    .HASH_INDEX(HASH_INDEX), .HASH_HIT(HASH_HIT), .MDC(MDC),
    .MDIO_OE(MDIO_OE), .MDIO_I(MDIO_I));

// ==== testbench/emi_mac_regs_tb.sv ====
// Self-checking bench for the MAC register block.
// Assumes the PHY model on the link and a zero-wait APB slave.
`timescale 1ns/100ps
module emi_mac_regs_tb;
    reg mclk = 1'b0, rst = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
    reg link = 1'b0, tx_buffer_not_queued = 1'b0;
    reg [11:0] pa = 12'h000;
    reg [31:0] pd = 32'h0, q;
    reg [7:0] ev = 8'h00;
    reg [5:0] hidx = 6'h00;
    reg [63:0] hv = {32'h2, 32'h80000001};
    reg [3:0] row [0:7] = '{4'ha, 4'h1, 4'h2, 4'h4, 4'h5, 4'h7, 4'h8, 4'hb};
    reg [31:0] man [0:1] = '{32'h500ea5c3, 32'h600e0000};
    wire [31:0] prdata, rx;
    wire pready, hit, irq, mdc, mdo, moe, mdi;
    integer comparisons = 0, miscompares = 0, cyc = 0, i;
    always #2.5 mclk = ~mclk;
    emi_mac_regs i_dut (.MCLK(mclk), .RESET(rst), .PSEL(psel),
        .PENABLE(pen), .PWRITE(pwr), .PADDR(pa), .PWDATA(pd),
        .PRDATA(prdata), .PREADY(pready), .PSLVERR(), .RX_STORE_FAIL(ev[0]),
        .RX_COMPLETE(ev[1]), .RX_NO_BUFFER(ev[2]), .TX_UNDERRUN(ev[3]),
        .TX_RETRY_LIMIT(ev[4]), .TX_FRAME_DONE(ev[5]), .TX_ALL_DONE(ev[6]),
        .TX_BUFFER_NOT_QUEUED(tx_buffer_not_queued), .DMA_ABORT(ev[7]), .LINK_PIN(link),
        .HASH_INDEX(hidx), .HASH_HIT(hit), .IRQ(irq), .MDC(mdc),
        .MDIO_O(mdo), .MDIO_OE(moe), .MDIO_I(mdi));
    emi_phy_model i_phy (.mdc(mdc), .mdo(mdo), .moe(moe), .mdi(mdi), .rx(rx));
    task apb(input w, input [11:0] a, input [31:0] d);
        @(posedge mclk);
        psel <= 1'b1;
        pwr <= w;
        pa <= a;
        pd <= d;
        @(posedge mclk);
        pen <= 1'b1;
        @(posedge mclk);
        while (pready !== 1'b1) @(posedge mclk);
        q = prdata;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask
    task chk(input [31:0] g, input [31:0] e);
        comparisons = comparisons + 1;
        if (g !== e) begin
            miscompares = miscompares + 1;
            $display("MISMATCH %0t %h %h", $time, g, e);
        end
    endtask
    task rd(input [11:0] a, input [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(q, e);
    endtask
    task wrap_up;
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            miscompares = miscompares + 1;
            wrap_up;
        end
    end
    initial begin
        repeat (20) @(posedge mclk);
        rst <= 1'b0;
        rd(12'h01c, 32'hfff);
        apb(1'b0, 12'h000, 32'h0);
        chk(q & 32'hc00, 32'h800);
        apb(1'b1, 12'h014, 32'hfff);
        apb(1'b1, 12'h018, 32'h800);
        rd(12'h01c, 32'h800);
        for (i = 0; i < 8; i = i + 1) begin
            ev <= 8'h01 << i;
            @(posedge mclk);
            ev <= 8'h00;
            @(posedge mclk);
            chk(irq, row[i] != 4'hb);
            rd(12'h010, 32'h1 << row[i]);
            @(posedge mclk);
            chk(irq, 1'b0);
        end
        $display("event rows done");
        apb(1'b0, 12'h00c, 32'h0);
        chk(q & 32'h4, 32'h4);
        apb(1'b1, 12'h00c, 32'h4);
        apb(1'b0, 12'h00c, 32'h0);
        chk(q & 32'h4, 32'h0);
        apb(1'b1, 12'h008, 32'h0);
        rd(12'h010, 32'h8);
        tx_buffer_not_queued <= 1'b1;
        apb(1'b1, 12'h008, 32'h0);
        apb(1'b0, 12'h008, 32'h0);
        chk(q & 32'h10, 32'h10);
        rd(12'h010, 32'h40);
        tx_buffer_not_queued <= 1'b0;
        rd(12'h010, 32'h0);
        link <= 1'b1;
        rd(12'h010, 32'h200);
        rd(12'h030, 32'h0);
        $display("transmit and link done");
        apb(1'b1, 12'h024, hv[31:0]);
        apb(1'b1, 12'h028, hv[63:32]);
        rd(12'h024, hv[31:0]);
        rd(12'h028, hv[63:32]);
        for (i = 0; i < 64; i = i + 1) begin
            hidx <= i[5:0];
            @(posedge mclk);
            chk(hit, hv[i]);
        end
        $display("hash done");
        apb(1'b1, 12'h000, 32'h0);
        for (i = 0; i < 2; i = i + 1) begin
            apb(1'b1, 12'h020, man[i]);
            apb(1'b0, 12'h004, 32'h0);
            chk(q & 32'h4, 32'h4);
            while (moe) @(posedge mclk);
            rd(12'h010, 32'h1);
            rd(12'h020, man[i]);
            chk(rx, man[i]);
            apb(1'b0, 12'h004, 32'h0);
            chk(q & 32'h6, {29'h0, 1'b0, mdi, 1'b0});
        end
        $display("management done");
        ev <= 8'h02;
        @(posedge mclk);
        ev <= 8'h00;
        rst <= 1'b1;
        repeat (20) @(posedge mclk);
        rst <= 1'b0;
        rd(12'h01c, 32'hfff);
        chk(irq, 1'b0);
        $display("reset done");
        wrap_up;
    end
endmodule
